/* pfm_defs.svh */
// Purpose: constants for the program flash self-write controller
// Assumes: 40 MHz clock
// Notes: timing counts derived from times in ns
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH
`define CLK_PERIOD_NS 25
`define ROW_WORDS 32
`define LATCH_WORDS 64
`define WORDS_SMALL 8192
`define WORDS_LARGE 16384
`define ERASE_TIME_NS 2000000
`define WRITE_TIME_NS 2000000
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASED_WORD 16'hffff
`define NOP_WORD 16'h0000
`endif

/* pfm_pkg.sv */
// Purpose: types for the program flash self-write controller
// Assumes: nothing
// Notes: one-hot state codes
package pfm_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_READ  = 4'h2,
    ST_ERASE = 4'h4,
    ST_WRITE = 4'h8
  } seq_state_t;
  typedef enum logic [1:0] {
    CMD_ROW_ERASE = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_BULK_ERASE = 2'h2
  } op_cmd_t;
endpackage

/* pfm_timer_if.sv */
// Purpose: link between sequencer and programming timer
// Assumes: one clock
// Notes: start pulse, done pulse
`timescale 1ns/1ps
interface pfm_timer_if;
  logic start;
  logic [31:0] count;
  logic busy;
  logic done;
  modport ctrl (output start, output count, input busy, input done);
  modport tmr (input start, input count, output busy, output done);
endinterface

/* pfm_prog_timer.sv */
// Purpose: internal programming timer
// Assumes: count at least one
// Notes: done is a single-cycle pulse
`timescale 1ns/1ps
module pfm_prog_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  pfm_timer_if.tmr tif
);
  logic [31:0] remain;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= 32'h0;
      tif.busy <= 1'b0;
      tif.done <= 1'b0;
    end else begin
      tif.done <= 1'b0;
      if (tif.start && !tif.busy) begin
        remain <= tif.count;
        tif.busy <= 1'b1;
      end else if (tif.busy) begin
        if (remain <= 32'h1) begin
          tif.busy <= 1'b0;
          tif.done <= 1'b1;
        end else begin
          remain <= remain - 32'h1;
        end
      end
    end
  end

  tmr_done_a: assert property (@(posedge clk_i) // [RULE_06]
    disable iff (!rst_n_i) tif.done |-> $past(tif.busy))
    else $error("timer done without busy");
endmodule

/* pfm_self_write.sv */
// Purpose: program flash array controller with write latches
// Assumes: core keeps to row copy-erase-reload when merging data
// Notes: byte reads, row erase, block write, fetch stall
// Notes on behaviour
// [RULE_01] array read, written, erased during normal run
// [RULE_02] each read returns a single byte
// [RULE_03] writes and erases act on whole blocks
// [RULE_04] bulk erase from core code refused
// [RULE_05] busy operation stalls fetch, blocks accesses
// [RULE_06] internal timer ends write and erase
// [RULE_07] any pattern stored; invalid word is nop
// [RULE_08] array word is 16 bits
// [RULE_09] array split in rows; row smallest erase
// [RULE_10] erased row programmable whole or part
// [RULE_11] latches hidden; filled by latch-register writes
// [RULE_12] software merges row via ram before rewrite
// [RULE_13] unprogrammed locations writable without erase
// [RULE_14] capacity 8192 or 16384 words by variant
// [RULE_15] latches hold until used, then erased
`timescale 1ns/1ps
`include "pfm_defs.svh"
module pfm_self_write #(
  parameter int WORDS = `WORDS_LARGE,
  parameter int ROW_WORDS = `ROW_WORDS,
  parameter int LATCH_WORDS = `LATCH_WORDS,
  parameter int ERASE_CYCLES = `ERASE_CYCLES,
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic RD_REQ_I,
  input wire logic [$clog2(WORDS)-1:0] RD_WADDR_I,
  input wire logic RD_HIGH_I,
  input wire logic LATCH_WR_I,
  input wire logic [7:0] LATCH_DATA_I,
  input wire logic OP_REQ_I,
  input wire pfm_pkg::op_cmd_t OP_CMD_I,
  input wire logic [$clog2(WORDS)-1:0] OP_WADDR_I,
  input wire logic FETCH_REQ_I,
  input wire logic [$clog2(WORDS)-1:0] FETCH_WADDR_I,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic [15:0] FETCH_DATA_O,
  output logic FETCH_VALID_O,
  output logic STALL_O,
  output logic OP_DONE_O,
  output logic OP_REFUSED_O
);
  localparam int AW = $clog2(WORDS);
  localparam int LW = $clog2(LATCH_WORDS);
  localparam int RW = $clog2(ROW_WORDS);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] flash_mem [WORDS]; // [RULE_08] [RULE_14]
  logic [15:0] latch_mem [LATCH_WORDS];
  logic [LW:0] latch_ptr;
  logic [AW-1:0] op_base;
  pfm_pkg::seq_state_t state;
  pfm_timer_if tif ();

  pfm_prog_timer u_timer (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .tif(tif)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic accept_op;
  assign accept_op = OP_REQ_I && state == pfm_pkg::ST_IDLE
    && OP_CMD_I != pfm_pkg::CMD_BULK_ERASE; // [RULE_04]

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= pfm_pkg::ST_IDLE;
      op_base <= '0;
      tif.start <= 1'b0;
      tif.count <= 32'h1;
      OP_DONE_O <= 1'b0;
      OP_REFUSED_O <= 1'b0;
      STALL_O <= 1'b0;
    end else begin
      tif.start <= 1'b0;
      OP_DONE_O <= 1'b0;
      OP_REFUSED_O <= OP_REQ_I && state == pfm_pkg::ST_IDLE
        && OP_CMD_I == pfm_pkg::CMD_BULK_ERASE; // [RULE_04]
      unique case (state)
        pfm_pkg::ST_IDLE: begin
          if (accept_op) begin // [RULE_01]
            tif.start <= 1'b1;
            STALL_O <= 1'b1; // [RULE_05]
            if (OP_CMD_I == pfm_pkg::CMD_ROW_ERASE) begin
              // [RULE_03] [RULE_09]
              op_base <= OP_WADDR_I & ~AW'(ROW_WORDS - 1);
              tif.count <= 32'(ERASE_CYCLES);
              state <= pfm_pkg::ST_ERASE;
            end else begin
              op_base <= OP_WADDR_I & ~AW'(LATCH_WORDS - 1); // [RULE_03]
              tif.count <= 32'(WRITE_CYCLES);
              state <= pfm_pkg::ST_WRITE;
            end
          end
        end
        pfm_pkg::ST_READ: begin
          state <= pfm_pkg::ST_IDLE;
        end
        pfm_pkg::ST_ERASE, pfm_pkg::ST_WRITE: begin
          if (tif.done) begin // [RULE_06]
            state <= pfm_pkg::ST_IDLE;
            STALL_O <= 1'b0;
            OP_DONE_O <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // array update at completion
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (tif.done && state == pfm_pkg::ST_ERASE) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        flash_mem[op_base + AW'(i)] <= `ERASED_WORD;
      end
    end else if (tif.done && state == pfm_pkg::ST_WRITE) begin
      // programming only clears bits, so erased words take any value
      for (int i = 0; i < LATCH_WORDS; i++) begin // [RULE_10] [RULE_13]
        flash_mem[op_base + AW'(i)] <=
          flash_mem[op_base + AW'(i)] & latch_mem[i]; // [RULE_07]
      end
    end
  end

  // ----------------------------------------
  // write latches
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      latch_ptr <= '0;
      for (int i = 0; i < LATCH_WORDS; i++) begin
        latch_mem[i] <= `ERASED_WORD;
      end
    end else if (tif.done && state == pfm_pkg::ST_WRITE) begin
      latch_ptr <= '0; // [RULE_15]
      for (int i = 0; i < LATCH_WORDS; i++) begin
        latch_mem[i] <= `ERASED_WORD;
      end
    end else if (LATCH_WR_I && state == pfm_pkg::ST_IDLE) begin
      // [RULE_11] low byte then high byte, pointer wraps
      if (latch_ptr[0]) begin
        latch_mem[latch_ptr[LW:1]][15:8] <= LATCH_DATA_I;
      end else begin
        latch_mem[latch_ptr[LW:1]][7:0] <= LATCH_DATA_I;
      end
      latch_ptr <= latch_ptr + 1'b1;
    end
  end

  // ----------------------------------------
  // byte reads and fetch
  // ----------------------------------------
  logic [15:0] fetch_word;
  assign fetch_word = flash_mem[FETCH_WADDR_I];

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RD_DATA_O <= 8'h0;
      RD_VALID_O <= 1'b0;
      FETCH_DATA_O <= `NOP_WORD;
      FETCH_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= 1'b0;
      FETCH_VALID_O <= 1'b0;
      if (RD_REQ_I && state == pfm_pkg::ST_IDLE && !accept_op) begin
        RD_DATA_O <= RD_HIGH_I ? flash_mem[RD_WADDR_I][15:8]
                               : flash_mem[RD_WADDR_I][7:0]; // [RULE_02]
        RD_VALID_O <= 1'b1;
      end
      if (FETCH_REQ_I && state == pfm_pkg::ST_IDLE && !accept_op) begin
        FETCH_DATA_O <= fetch_word; // [RULE_05]
        FETCH_VALID_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  // stall cycles since the last accepted op
  logic [31:0] busy_cycles;
  // kind of the op in flight
  logic last_erase;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      busy_cycles <= 32'h0;
    end else if (accept_op) begin
      busy_cycles <= 32'h0;
    end else if (STALL_O) begin
      busy_cycles <= busy_cycles + 32'h1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      last_erase <= 1'b0;
    end else if (accept_op) begin
      last_erase <= OP_CMD_I == pfm_pkg::CMD_ROW_ERASE;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence op_start_s;
    accept_op;
  endsequence

  sequence bulk_req_s;
    OP_REQ_I && state == pfm_pkg::ST_IDLE
      && OP_CMD_I == pfm_pkg::CMD_BULK_ERASE;
  endsequence

  sequence erase_end_s;
    OP_DONE_O && last_erase;
  endsequence

  sequence write_end_s;
    OP_DONE_O && !last_erase;
  endsequence

  no_bulk_a: assert property (@(posedge REF_CLK_I) // [RULE_04]
    disable iff (!RESET_N_I) bulk_req_s |=> OP_REFUSED_O && !STALL_O)
    else $error("bulk erase not refused");
  refuse_idle_a: assert property (@(posedge REF_CLK_I) // [RULE_04]
    disable iff (!RESET_N_I) OP_REFUSED_O |-> state == pfm_pkg::ST_IDLE)
    else $error("refused bulk erase changed state");

  stall_on_op_a: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (!RESET_N_I) op_start_s |=> STALL_O[*2])
    else $error("no stall after start");
  no_fetch_busy_a: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (!RESET_N_I) STALL_O |=> !FETCH_VALID_O && !RD_VALID_O)
    else $error("access during busy");
  busy_latch_a: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (!RESET_N_I)
    STALL_O && !tif.done |=> $stable(latch_ptr) && $stable(latch_mem[0]))
    else $error("latches changed during busy");
  busy_op_a: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (!RESET_N_I)
    OP_REQ_I && STALL_O |=> $stable(op_base) && !OP_REFUSED_O)
    else $error("request taken during busy");
  fetch_one_a: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (!RESET_N_I)
    FETCH_REQ_I && state == pfm_pkg::ST_IDLE && !accept_op
    |=> FETCH_VALID_O)
    else $error("fetch not answered");

  timer_end_a: assert property (@(posedge REF_CLK_I) // [RULE_06]
    disable iff (!RESET_N_I) OP_DONE_O |-> $past(tif.done))
    else $error("done without timer");
  stall_release_a: assert property (@(posedge REF_CLK_I) // [RULE_06]
    disable iff (!RESET_N_I) $fell(STALL_O) |-> OP_DONE_O)
    else $error("stall dropped early");
  erase_time_a: assert property (@(posedge REF_CLK_I) // [RULE_06]
    disable iff (!RESET_N_I)
    erase_end_s |-> busy_cycles == 32'(ERASE_CYCLES + 2))
    else $error("erase length wrong");
  write_time_a: assert property (@(posedge REF_CLK_I) // [RULE_06]
    disable iff (!RESET_N_I)
    write_end_s |-> busy_cycles == 32'(WRITE_CYCLES + 2))
    else $error("write length wrong");

  erase_fill_a: assert property (@(posedge REF_CLK_I) // [RULE_09]
    disable iff (!RESET_N_I)
    erase_end_s |-> flash_mem[op_base] == `ERASED_WORD
      && flash_mem[op_base + AW'(ROW_WORDS - 1)] == `ERASED_WORD)
    else $error("row not erased");

  latch_clear_a: assert property (@(posedge REF_CLK_I) // [RULE_15]
    disable iff (!RESET_N_I)
    tif.done && state == pfm_pkg::ST_WRITE |=> latch_ptr == '0)
    else $error("latch pointer not reset");
  latch_erased_a: assert property (@(posedge REF_CLK_I) // [RULE_15]
    disable iff (!RESET_N_I)
    write_end_s |-> latch_ptr == '0
      && latch_mem[LATCH_WORDS - 1] == `ERASED_WORD)
    else $error("latches not erased after write");
  latch_step_a: assert property (@(posedge REF_CLK_I) // [RULE_11]
    disable iff (!RESET_N_I)
    LATCH_WR_I && state == pfm_pkg::ST_IDLE && !tif.done
    |=> latch_ptr == $past(latch_ptr) + 1'b1)
    else $error("latch pointer not advanced");

  read_one_a: assert property (@(posedge REF_CLK_I) // [RULE_02]
    disable iff (!RESET_N_I)
    RD_REQ_I && state == pfm_pkg::ST_IDLE && !accept_op |=> RD_VALID_O)
    else $error("read not answered");
endmodule

/* core_model.sv */
// Purpose: processor core model, table reads and latch loads
// Assumes: requests launched 2 ns after the rising edge
// Notes: released address and latch data lines show the inverse of their last value
`timescale 1ns/1ps
module core_model #(parameter int AW = 14) (
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_req_o,
  output logic [AW-1:0] rd_waddr_o,
  output logic rd_high_o,
  output logic latch_wr_o,
  output logic [7:0] latch_data_o
);
  initial begin
    rd_req_o = 1'b0;
    rd_waddr_o = '0;
    rd_high_o = 1'b0;
    latch_wr_o = 1'b0;
    latch_data_o = 8'h00;
  end
  // one byte per table read
  task automatic rd(input logic [AW-1:0] a, input logic hi,
                    output logic v, output logic [7:0] d);
    rd_req_o = 1'b1;
    rd_waddr_o = a;
    rd_high_o = hi;
    @(posedge clk_i);
    #2;
    v = rd_valid_i;
    d = rd_data_i;
    rd_req_o = 1'b0;
    rd_waddr_o = ~a;
    @(posedge clk_i);
    #2;
  endtask
  // whole merged words, low byte first, by consecutive latch writes
  task automatic load(input int n, input logic ramp,
                      input logic [15:0] v);
    logic [15:0] w;
    latch_wr_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      w = ramp ? {8'(i), ~8'(i)} : ((i == n - 1) ? v : 16'hffff);
      latch_data_o = w[7:0];
      @(posedge clk_i);
      #2;
      latch_data_o = w[15:8];
      @(posedge clk_i);
      #2;
    end
    latch_wr_o = 1'b0;
    latch_data_o = ~latch_data_o;
    @(posedge clk_i);
    #2;
  endtask
endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the flash self-write controller
// Assumes: timer counts shortened to 5 cycles
// Notes: core model drives reads and latch loads
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, op_req, fetch_req, rd_req, rd_high, latch_wr;
  logic rd_valid, fetch_valid, stall, op_done, op_refused, v;
  logic [13:0] rd_waddr, op_waddr, fetch_waddr;
  logic [7:0] latch_data, rd_data, d;
  logic [15:0] fetch_data, w;
  pfm_pkg::op_cmd_t op_cmd;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  pfm_self_write #(.ERASE_CYCLES(5), .WRITE_CYCLES(5)) u_dut (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .RD_REQ_I(rd_req),
    .RD_WADDR_I(rd_waddr), .RD_HIGH_I(rd_high), .LATCH_WR_I(latch_wr),
    .LATCH_DATA_I(latch_data), .OP_REQ_I(op_req), .OP_CMD_I(op_cmd),
    .OP_WADDR_I(op_waddr), .FETCH_REQ_I(fetch_req),
    .FETCH_WADDR_I(fetch_waddr), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .FETCH_DATA_O(fetch_data),
    .FETCH_VALID_O(fetch_valid), .STALL_O(stall), .OP_DONE_O(op_done),
    .OP_REFUSED_O(op_refused));
  core_model u_core (.clk_i(clk), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_req_o(rd_req), .rd_waddr_o(rd_waddr),
    .rd_high_o(rd_high), .latch_wr_o(latch_wr),
    .latch_data_o(latch_data));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  task automatic rdw(input logic [13:0] a, input logic [15:0] e);
    logic v0, v1;
    logic [7:0] lo, hi;
    u_core.rd(a, 1'b0, v0, lo);
    u_core.rd(a, 1'b1, v1, hi);
    chk({14'h0, v0, v1}, 16'h3);
    chk({hi, lo}, e);
  endtask
  task automatic op_go(input pfm_pkg::op_cmd_t c, input logic [13:0] a);
    op_req = 1'b1;
    op_cmd = c;
    op_waddr = a;
    tick();
    op_req = 1'b0;
    op_waddr = ~a;
  endtask
  task automatic op_wait;
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < 12) begin
      chk({15'h0, stall}, 16'h1);
      tick();
      n++;
    end
    chk({15'h0, op_done}, 16'h1);
    chk({15'h0, stall}, 16'h0);
    tick();
  endtask
  task automatic fetch(input logic [13:0] a);
    fetch_req = 1'b1;
    fetch_waddr = a;
    tick();
    fetch_req = 1'b0;
    fetch_waddr = ~a;
    v = fetch_valid;
    w = fetch_data;
    tick();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_erase;
    op_go(pfm_pkg::CMD_ROW_ERASE, 14'h0000);
    op_wait();
    op_go(pfm_pkg::CMD_ROW_ERASE, 14'h0025);
    op_wait();
    op_go(pfm_pkg::CMD_ROW_ERASE, 14'h3fe0);
    op_wait();
    rdw(14'h003f, 16'hffff);
    rdw(14'h3fff, 16'hffff);
  endtask
  task automatic s_write;
    u_core.load(64, 1'b1, 16'h0000);
    op_go(pfm_pkg::CMD_WRITE, 14'h0005);
    op_wait();
    for (int i = 0; i < 64; i += 31) rdw(14'(i), {8'(i), ~8'(i)});
    op_go(pfm_pkg::CMD_ROW_ERASE, 14'h0000);
    op_wait();
    rdw(14'h0000, 16'hffff);
    rdw(14'h0020, 16'h20df);
  endtask
  task automatic s_partial;
    u_core.load(1, 1'b0, 16'h1234);
    op_go(pfm_pkg::CMD_WRITE, 14'h0000);
    op_wait();
    rdw(14'h0001, 16'hffff);
    u_core.load(2, 1'b0, 16'h5678);
    op_go(pfm_pkg::CMD_WRITE, 14'h0000);
    op_wait();
    rdw(14'h0000, 16'h1234);
    rdw(14'h0001, 16'h5678);
  endtask
  task automatic s_stall;
    op_go(pfm_pkg::CMD_ROW_ERASE, 14'h3fe0);
    fetch(14'h0000);
    chk({15'h0, v}, 16'h0);
    u_core.rd(14'h0000, 1'b0, v, d);
    chk({15'h0, v}, 16'h0);
    op_go(pfm_pkg::CMD_WRITE, 14'h0000);
    chk({15'h0, op_refused}, 16'h0);
    op_wait();
    fetch(14'h0000);
    chk({v, w[14:0]}, 16'h9234);
  endtask
  task automatic s_bulk;
    op_go(pfm_pkg::CMD_BULK_ERASE, 14'h0000);
    chk({14'h0, op_refused, stall}, 16'h2);
    tick();
    rdw(14'h0000, 16'h1234);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    op_req = 1'b0;
    op_cmd = pfm_pkg::CMD_ROW_ERASE;
    op_waddr = 14'h0000;
    fetch_req = 1'b0;
    fetch_waddr = 14'h0000;
    repeat (20) @(posedge clk);
    #2;
    chk({15'h0, stall}, 16'h0);
    rst_n = 1'b1;
    tick();
    s_erase();
    s_write();
    s_partial();
    s_stall();
    s_bulk();
    print_verdict();
  end
endmodule
